/* File: inc/osdsh_pkg.sv */
// Constants for the overlay window shadow register bank.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package osdsh_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NSH = 26;
  localparam int PAL_W = 8;
  localparam int PAL_N = 16;
  localparam int TKEY_W = 16;
  localparam int CTRL_W = 6;
  localparam int COMP_W = 8;
  localparam int TAB_DW = 3 * COMP_W;

  // ------------------------------------------------------------
  // Shadowed register indexes, byte address is four times these
  // ------------------------------------------------------------
  localparam int SH_MODE = 0;
  localparam int SH_VIDMODE = 1;
  localparam int SH_BMP0 = 2;
  localparam int SH_BMP1 = 3;
  localparam int SH_ATTR = 4;
  localparam int SH_CURSOR = 5;
  localparam int SH_BASE_XY = 6;
  localparam int SH_POS0 = 7;
  localparam int SH_OFST0 = 17;
  localparam int SH_ADDR0 = 21;
  localparam int SH_PPADDR = 25;
  localparam logic [DATA_W-1:0] SH_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // Immediate registers
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_CTRL = 12'h100;
  localparam logic [ADDR_W-1:0] A_TKEY = 12'h104;
  localparam logic [ADDR_W-1:0] A_CPAL = 12'h108;
  localparam logic [ADDR_W-1:0] A_TYCB = 12'h10C;
  localparam logic [ADDR_W-1:0] A_TCR = 12'h110;
  localparam logic [ADDR_W-1:0] A_IRQ_ST = 12'h114;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 12'h118;
  localparam logic [ADDR_W-1:0] A_PAL_BASE = 12'h120;
  localparam logic [ADDR_W-1:0] A_PAL_END = 12'h140;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_CHROMA = 0;
  localparam int CTRL_RGB_EN = 1;
  localparam int CTRL_RGB_WIN = 2;
  localparam int CTRL_ROM_SEL = 3;
  localparam int CTRL_PP_TOG = 4;
  localparam int CTRL_PP_REV = 5;
  localparam int BMP_TE = 2;
  localparam int BMP_BW_LSB = 6;
  localparam int ATTR_MODE = 13;
  localparam int BMP_RGB565 = 14;

  // Bitmap bit width codes
  localparam logic [1:0] BW_1 = 2'h0;
  localparam logic [1:0] BW_2 = 2'h1;
  localparam logic [1:0] BW_4 = 2'h2;
  localparam logic [1:0] BW_8 = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: inc/osdsh_table_if.sv */
// Write and read port of the colour lookup RAM.
// Assumes both sides run on the one bank clock.
`timescale 1ns/10ps
interface osdsh_table_if #(parameter int AW = 8, parameter int DW = 24);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
               output rd_data);
endinterface

/* File: hdl/osdsh_table_ram.sv */
// Simple dual-port colour lookup RAM with registered read data.
// Assumes the controller never writes and reads in the same cycle.
`timescale 1ns/10ps
module osdsh_table_ram #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  osdsh_table_if.mem port
);
  // Contents are not reset so they survive a module reset
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;

  always_ff @(posedge aclk) begin
    if (port.wr_en) begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_reg <= '0;
    end else if (port.rd_en) begin
      rd_data_reg <= mem[port.rd_addr];
    end
  end

  assign port.rd_data = rd_data_reg;
endmodule

/* File: hdl/osdsh_top.sv */
// Overlay window shadow register bank with AXI4-Lite access.
// Assumes vsync_n comes from the encoder, asynchronous to aclk.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - RGB24 format applies to one video window
// - Shadowed writes wait for next frame start
// - Window mode controls are shadowed
// - Base, positions and sizes shadowed together
// - Line offsets and source addresses shadowed
// - Alternate ping-pong address is shadowed
// - Ping-pong toggle and reverse controls
// - Palette entry chosen by bitmap bit width
// - Lookup RAM loaded one entry per write
// - RGB565 transparency key compared per pixel
// - Attribute enable shared; blink fields shadowed
// - Chroma order and ROM table select controls
// - Cursor fields shadowed, palette address held
// - Vsync copies pending; interrupt follows update
// - Busy flag while lookup RAM write pending
module osdsh_top #(
  parameter int TABLE_DEPTH = 256
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [osdsh_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [osdsh_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [osdsh_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [osdsh_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  input wire logic vsync_n,
  input wire logic table_rd_en,
  input wire logic [$clog2(TABLE_DEPTH)-1:0] table_rd_addr,
  output logic [osdsh_pkg::TAB_DW-1:0] table_rd_data,
  input wire logic bmp_valid,
  input wire logic bmp_sel,
  input wire logic [15:0] bmp_pix,
  output logic [osdsh_pkg::PAL_W-1:0] palette_addr,
  output logic bitmap_transparent,
  output logic [osdsh_pkg::NSH*osdsh_pkg::DATA_W-1:0] active_cfg,
  output logic chroma_order_swap,
  output logic rom_table_select,
  output logic [osdsh_pkg::PAL_W-1:0] cursor_palette_addr,
  output logic [osdsh_pkg::DATA_W-1:0] video0_fetch_addr,
  output logic video0_rgb24,
  output logic video1_rgb24,
  output logic frame_irq
);
  localparam int TAB_AW = $clog2(TABLE_DEPTH);

  if (TABLE_DEPTH < 2 || TABLE_DEPTH > 256 ||
      (1 << TAB_AW) != TABLE_DEPTH) begin : g_bad_depth
    $error("TABLE_DEPTH must be a power of two from 2 to 256");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [osdsh_pkg::ADDR_W-1:0] awaddr;
    logic [osdsh_pkg::DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [osdsh_pkg::DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [2:0] vs_sync;
    logic upd_done;
    logic [osdsh_pkg::NSH-1:0][osdsh_pkg::DATA_W-1:0] pend;
    logic [osdsh_pkg::NSH-1:0][osdsh_pkg::DATA_W-1:0] act;
    logic [osdsh_pkg::CTRL_W-1:0] ctrl;
    logic [osdsh_pkg::TKEY_W-1:0] tkey;
    logic [osdsh_pkg::PAL_W-1:0] cpal;
    logic [15:0] tycb;
    logic [15:0] tcr;
    logic tw_pend;
    logic [1:0][osdsh_pkg::PAL_N-1:0][osdsh_pkg::PAL_W-1:0] pal;
    logic irq_st;
    logic irq_mask;
    logic irq;
    logic pp_phase;
    logic [osdsh_pkg::DATA_W-1:0] fetch_addr;
    logic [osdsh_pkg::PAL_W-1:0] pal_addr;
    logic transp;
    logic rgb0;
    logic rgb1;
  } osdsh_state_t;

  osdsh_state_t st_reg;
  osdsh_state_t st_next;
  logic frame_start;
  osdsh_table_if #(.AW(TAB_AW), .DW(osdsh_pkg::TAB_DW)) tab_if ();

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------
  function automatic logic [33:0] rd_word(
      input logic [osdsh_pkg::ADDR_W-1:0] a, input osdsh_state_t s);
    logic [31:0] d;
    logic [1:0] r;
    d = '0;
    r = osdsh_pkg::RESP_OKAY;
    if (int'(a[osdsh_pkg::ADDR_W-1:2]) < osdsh_pkg::NSH) begin
      d = s.pend[a[osdsh_pkg::ADDR_W-1:2]];
    end else begin
      case (a)
        osdsh_pkg::A_CTRL: d = {23'h000000, s.tw_pend, 2'h0, s.ctrl};
        osdsh_pkg::A_TKEY: d = {16'h0000, s.tkey};
        osdsh_pkg::A_CPAL: d = {24'h000000, s.cpal};
        osdsh_pkg::A_TYCB: d = {16'h0000, s.tycb};
        osdsh_pkg::A_TCR: d = {16'h0000, s.tcr};
        osdsh_pkg::A_IRQ_ST: d = {31'h00000000, s.irq_st};
        osdsh_pkg::A_IRQ_MASK: d = {31'h00000000, s.irq_mask};
        default: begin
          if (a >= osdsh_pkg::A_PAL_BASE && a < osdsh_pkg::A_PAL_END) begin
            d = s.pal[a[4]][{a[3:2], 2'h0} +: 4];
          end else begin
            r = osdsh_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    return {r, d};
  endfunction

  assign frame_start = st_reg.vs_sync[2] && !st_reg.vs_sync[1];

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [osdsh_pkg::ADDR_W-1:0] a;
    logic [31:0] wv;
    logic [osdsh_pkg::DATA_W-1:0] bw_cfg;
    logic [3:0] pidx;
    logic pp_sel;
    logic [33:0] rw;
    a = st_reg.awaddr;
    rw = '0;
    wv = '0;
    bw_cfg = '0;
    pidx = '0;
    pp_sel = 1'b0;
    st_next = st_reg;
    // First stage only feeds the second; edge uses stages two and three
    st_next.vs_sync = {st_reg.vs_sync[1:0], vsync_n};
    st_next.upd_done = frame_start;
    if (frame_start) begin
      st_next.act = st_reg.pend;
      st_next.pp_phase = !st_reg.pp_phase;
    end
    if (st_reg.tw_pend && !table_rd_en) begin
      st_next.tw_pend = 1'b0;
    end
    if (st_reg.upd_done) begin
      st_next.irq_st = 1'b1;
    end

    // Write channel
    if (awvalid && st_reg.awready) begin
      st_next.aw_held = 1'b1;
      st_next.awaddr = awaddr;
    end
    if (wvalid && st_reg.wready) begin
      st_next.w_held = 1'b1;
      st_next.wdata = wdata;
      st_next.wstrb = wstrb;
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      rw = rd_word(a, st_reg);
      st_next.bresp = rw[33:32];
      if (int'(a[osdsh_pkg::ADDR_W-1:2]) < osdsh_pkg::NSH) begin
        wv = merge(st_reg.pend[a[osdsh_pkg::ADDR_W-1:2]], st_reg.wdata,
                   st_reg.wstrb);
        st_next.pend[a[osdsh_pkg::ADDR_W-1:2]] = wv;
        if (int'(a[osdsh_pkg::ADDR_W-1:2]) == osdsh_pkg::SH_BMP1 ||
            int'(a[osdsh_pkg::ADDR_W-1:2]) == osdsh_pkg::SH_ATTR) begin
          // One enable seen through two registers
          st_next.pend[osdsh_pkg::SH_BMP1][osdsh_pkg::ATTR_MODE] =
            wv[osdsh_pkg::ATTR_MODE];
          st_next.pend[osdsh_pkg::SH_ATTR][osdsh_pkg::ATTR_MODE] =
            wv[osdsh_pkg::ATTR_MODE];
        end
      end else begin
        case (a)
          osdsh_pkg::A_CTRL: begin
            if (st_reg.wstrb[0]) begin
              st_next.ctrl = st_reg.wdata[osdsh_pkg::CTRL_W-1:0];
            end
          end
          osdsh_pkg::A_TKEY: begin
            wv = merge({16'h0000, st_reg.tkey}, st_reg.wdata, st_reg.wstrb);
            st_next.tkey = wv[osdsh_pkg::TKEY_W-1:0];
          end
          osdsh_pkg::A_CPAL: begin
            wv = merge({24'h000000, st_reg.cpal}, st_reg.wdata,
                       st_reg.wstrb);
            st_next.cpal = wv[osdsh_pkg::PAL_W-1:0];
          end
          osdsh_pkg::A_TYCB: begin
            wv = merge({16'h0000, st_reg.tycb}, st_reg.wdata, st_reg.wstrb);
            st_next.tycb = wv[15:0];
          end
          osdsh_pkg::A_TCR: begin
            // A new entry while busy replaces the queued one
            wv = merge({16'h0000, st_reg.tcr}, st_reg.wdata, st_reg.wstrb);
            st_next.tcr = wv[15:0];
            st_next.tw_pend = 1'b1;
          end
          osdsh_pkg::A_IRQ_ST: begin
            if (st_reg.wstrb[0] && st_reg.wdata[0] && !st_reg.upd_done) begin
              st_next.irq_st = 1'b0;
            end
          end
          osdsh_pkg::A_IRQ_MASK: begin
            if (st_reg.wstrb[0]) begin
              st_next.irq_mask = st_reg.wdata[0];
            end
          end
          default: begin
            if (a >= osdsh_pkg::A_PAL_BASE && a < osdsh_pkg::A_PAL_END) begin
              st_next.pal[a[4]][{a[3:2], 2'h0} +: 4] =
                merge(st_reg.pal[a[4]][{a[3:2], 2'h0} +: 4], st_reg.wdata,
                      st_reg.wstrb);
            end
          end
        endcase
      end
    end
    st_next.awready = !st_next.aw_held;
    st_next.wready = !st_next.w_held;

    // Read channel
    if (st_reg.arready && arvalid) begin
      {st_next.rresp, st_next.rdata} = rd_word(araddr, st_reg);
      st_next.rvalid = 1'b1;
    end else if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.arready = !st_next.rvalid;

    st_next.irq = st_next.irq_st && st_next.irq_mask;

    // Pixel side helpers
    pp_sel = (st_reg.ctrl[osdsh_pkg::CTRL_PP_TOG] && st_next.pp_phase) ^
             st_reg.ctrl[osdsh_pkg::CTRL_PP_REV];
    st_next.fetch_addr = pp_sel ? st_next.act[osdsh_pkg::SH_PPADDR] :
                         st_next.act[osdsh_pkg::SH_ADDR0];
    st_next.rgb0 = st_reg.ctrl[osdsh_pkg::CTRL_RGB_EN] &&
                   !st_reg.ctrl[osdsh_pkg::CTRL_RGB_WIN];
    st_next.rgb1 = st_reg.ctrl[osdsh_pkg::CTRL_RGB_EN] &&
                   st_reg.ctrl[osdsh_pkg::CTRL_RGB_WIN];
    bw_cfg = bmp_sel ? st_reg.act[osdsh_pkg::SH_BMP1] :
             st_reg.act[osdsh_pkg::SH_BMP0];
    if (bmp_valid) begin
      case (bw_cfg[osdsh_pkg::BMP_BW_LSB +: 2])
        osdsh_pkg::BW_1: pidx = {4{bmp_pix[0]}};
        osdsh_pkg::BW_2: pidx = {2{bmp_pix[1:0]}};
        default: pidx = bmp_pix[3:0];
      endcase
      st_next.pal_addr = st_reg.pal[bmp_sel][pidx];
      if (bw_cfg[osdsh_pkg::BMP_BW_LSB +: 2] == osdsh_pkg::BW_8) begin
        st_next.pal_addr = bmp_pix[osdsh_pkg::PAL_W-1:0];
      end
      st_next.transp = bw_cfg[osdsh_pkg::BMP_TE] &&
                       bw_cfg[osdsh_pkg::BMP_RGB565] &&
                       bmp_pix == st_reg.tkey;
    end
  end

  // Reset gives pending and active the same value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Lookup RAM
  // ------------------------------------------------------------
  assign tab_if.wr_en = st_reg.tw_pend && !table_rd_en;
  assign tab_if.wr_addr = st_reg.tcr[TAB_AW-1:0];
  assign tab_if.wr_data = {st_reg.tycb, st_reg.tcr[15:8]};
  assign tab_if.rd_en = table_rd_en;
  assign tab_if.rd_addr = table_rd_addr;

  osdsh_table_ram #(.DEPTH(TABLE_DEPTH), .WIDTH(osdsh_pkg::TAB_DW))
    u_ram (.aclk(aclk), .aresetn(aresetn), .port(tab_if.mem));

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign awready = st_reg.awready;
  assign wready = st_reg.wready;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign arready = st_reg.arready;
  assign rvalid = st_reg.rvalid;
  assign rdata = st_reg.rdata;
  assign rresp = st_reg.rresp;
  assign table_rd_data = tab_if.rd_data;
  assign palette_addr = st_reg.pal_addr;
  assign bitmap_transparent = st_reg.transp;
  assign active_cfg = st_reg.act;
  assign chroma_order_swap = st_reg.ctrl[osdsh_pkg::CTRL_CHROMA];
  assign rom_table_select = st_reg.ctrl[osdsh_pkg::CTRL_ROM_SEL];
  assign cursor_palette_addr = st_reg.cpal;
  assign video0_fetch_addr = st_reg.fetch_addr;
  assign video0_rgb24 = st_reg.rgb0;
  assign video1_rgb24 = st_reg.rgb1;
  assign frame_irq = st_reg.irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [osdsh_pkg::PAL_W-1:0] pal2_expect;
  assign pal2_expect = st_reg.pal[bmp_sel][{2{bmp_pix[1:0]}}];

  sequence s_frame_edge;
    frame_start;
  endsequence
  sequence s_irq_set;
    ##1 st_reg.irq_st;
  endsequence

  a_hold_active: assert property (!frame_start |=>
    st_reg.act == $past(st_reg.act)) else $error("active changed midframe");
  a_frame_copy: assert property (s_frame_edge |=>
    st_reg.act == $past(st_reg.pend)) else $error("frame copy wrong");
  a_irq_follows: assert property (s_frame_edge |=> s_irq_set)
    else $error("frame interrupt missing");
  a_reset_equal: assert property ($rose(aresetn) |->
    st_reg.pend == st_reg.act) else $error("reset copies differ");
  a_busy_holds: assert property (st_reg.tw_pend && table_rd_en |=>
    st_reg.tw_pend) else $error("busy dropped while blocked");
  a_ram_write: assert property (tab_if.wr_en |=>
    u_ram.mem[$past(tab_if.wr_addr)] == $past(tab_if.wr_data))
    else $error("table write lost");
  a_rgb_off: assert property (!st_reg.ctrl[osdsh_pkg::CTRL_RGB_EN] |=>
    !video0_rgb24 && !video1_rgb24) else $error("rgb24 without enable");
  a_pal_two_bit: assert property (bmp_valid &&
    (bmp_sel ? st_reg.act[osdsh_pkg::SH_BMP1][osdsh_pkg::BMP_BW_LSB +: 2] :
     st_reg.act[osdsh_pkg::SH_BMP0][osdsh_pkg::BMP_BW_LSB +: 2]) ==
    osdsh_pkg::BW_2 |=> palette_addr == $past(pal2_expect))
    else $error("two-bit palette mapping wrong");
  a_pingpong_plain: assert property (frame_start &&
    !st_reg.ctrl[osdsh_pkg::CTRL_PP_TOG] &&
    !st_reg.ctrl[osdsh_pkg::CTRL_PP_REV] |=>
    video0_fetch_addr == $past(st_reg.pend[osdsh_pkg::SH_ADDR0]))
    else $error("fetch address not primary");
  a_transp_off: assert property (bmp_valid && !st_reg.tkey[0] &&
    bmp_pix[0] |=> !bitmap_transparent) else $error("key mismatch keyed");
endmodule

/* File: testbench/osdsh_venc_model.sv */
// Encoder model: sends one active-low frame sync pulse on request.
// Assumes the bank clock; the sync line idles high between frames.
`timescale 1ns/10ps
module osdsh_venc_model #(
  parameter int LOW_CYC = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_go,
  output logic vsync_n
);
  // ------------------------------------------------------------
  // Pulse generator
  // ------------------------------------------------------------
  int cnt = 0;

  // Low phase held several cycles so the bank's synchroniser sees it
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      vsync_n <= 1'b1;
    end else if (frame_go) begin
      cnt <= LOW_CYC;
      vsync_n <= 1'b0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt <= 0;
      vsync_n <= 1'b1;
    end
  end
endmodule

/* File: testbench/osdsh_top_tb.sv */
// Self-checking bench for the overlay shadow register bank.
// Assumes the package, the bank and the encoder model are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module osdsh_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, frame_irq, vsync_n;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, fetch_addr, d;
  logic tab_en = 1'b0, pix_valid = 1'b0, pix_sel = 1'b0, frame_go = 1'b0;
  logic [7:0] tab_addr = 8'h00, pal_addr, cur_pal;
  logic [15:0] pix = 16'h0000;
  logic [23:0] tab_data;
  logic [831:0] act;
  logic transp, chroma, rom_sel, v0_rgb, v1_rgb;
  int n_fail = 0, num_checks = 0, cycles = 0;
  int idx[13] = '{0, 1, 2, 4, 5, 6, 7, 9, 11, 13, 17, 21, 25};
  int mul[3] = '{15, 5, 1};

  // ------------------------------------------------------------
  // Clock, timeout and instances
  // ------------------------------------------------------------
  initial forever #2.5 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end

  osdsh_venc_model osdsh_venc_model_i (.aclk(aclk), .aresetn(aresetn),
    .frame_go(frame_go), .vsync_n(vsync_n));

  osdsh_top osdsh_top_i (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(1'b1), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(1'b1),
    .rdata(rdata), .rresp(rresp), .vsync_n(vsync_n), .table_rd_en(tab_en),
    .table_rd_addr(tab_addr), .table_rd_data(tab_data),
    .bmp_valid(pix_valid), .bmp_sel(pix_sel), .bmp_pix(pix),
    .palette_addr(pal_addr), .bitmap_transparent(transp),
    .active_cfg(act), .chroma_order_swap(chroma),
    .rom_table_select(rom_sel), .cursor_palette_addr(cur_pal),
    .video0_fetch_addr(fetch_addr), .video0_rgb24(v0_rgb),
    .video1_rgb24(v1_rgb), .frame_irq(frame_irq));

  // ------------------------------------------------------------
  // Bus, frame and pixel tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] ev(input int k);
    return {8'hA5, 8'(k), 8'h0F, 8'(k)};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
  endtask

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic frame();
    frame_go <= 1'b1;
    @(posedge aclk);
    frame_go <= 1'b0;
    repeat (12) @(posedge aclk);
  endtask

  task automatic px(input logic s, input logic [15:0] v);
    pix_sel <= s;
    pix <= v;
    pix_valid <= 1'b1;
    @(posedge aclk);
    pix_valid <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(12'h01C);
    `CHK(d, 32'h0)
    `CHK(act, 832'h0)
    rd(osdsh_pkg::A_CTRL);
    `CHK(d, 32'h0)
    rd(12'h200);
    `CHK(r, osdsh_pkg::RESP_SLVERR)
    `CHK(d, 32'h0)
    wr(12'h200, 32'hFFFF_FFFF);
    `CHK(r, osdsh_pkg::RESP_SLVERR)
    // Shadowed writes read back at once; active copy waits for the frame
    foreach (idx[j]) wr(12'(4 * idx[j]), ev(idx[j]));
    foreach (idx[j]) begin
      rd(12'(4 * idx[j]));
      `CHK(d, ev(idx[j]))
      `CHK(act[32*idx[j] +: 32], 32'h0)
    end
    frame();
    foreach (idx[j]) `CHK(act[32*idx[j] +: 32], ev(idx[j]))
    wr(12'h010, 32'h0000_2000);
    frame();
    rd(12'h00C);
    `CHK(d[13], 1'b1)
    `CHK(act[109], 1'b1)
    `CHK(fetch_addr, ev(21))
    wr(osdsh_pkg::A_CTRL, 32'h1 << osdsh_pkg::CTRL_PP_REV);
    repeat (2) @(posedge aclk);
    `CHK(fetch_addr, ev(25))
    wr(osdsh_pkg::A_CTRL, 32'h1 << osdsh_pkg::CTRL_PP_TOG);
    frame();
    d = fetch_addr;
    frame();
    `CHK(fetch_addr ^ d, ev(21) ^ ev(25))
    for (int k = 0; k < 4; k++) begin
      wr(osdsh_pkg::A_CTRL, 32'(k) << osdsh_pkg::CTRL_RGB_EN | 32'h9);
      repeat (2) @(posedge aclk);
      `CHK({v1_rgb, v0_rgb}, k[0] ? (k[1] ? 2'h2 : 2'h1) : 2'h0)
      `CHK({rom_sel, chroma}, 2'h3)
    end
    wr(osdsh_pkg::A_CPAL, 32'hC7);
    `CHK(cur_pal, 8'hC7)
    for (int w = 0; w < 4; w++)
      wr(12'(osdsh_pkg::A_PAL_BASE + 4 * w), 32'h43424140 + 32'h04040404 * w);
    for (int b = 0; b < 3; b++) begin
      wr(12'h008, 32'(b) << osdsh_pkg::BMP_BW_LSB);
      frame();
      for (int n = 0; n < (1 << (1 << b)); n++) begin
        px(1'b0, 16'(n));
        `CHK(pal_addr, 8'(8'h40 + n * mul[b]))
      end
    end
    wr(osdsh_pkg::A_TKEY, 32'h1234);
    wr(12'h008, 32'h4004);
    frame();
    px(1'b0, 16'h1234);
    `CHK(transp, 1'b1)
    px(1'b0, 16'h1235);
    `CHK(transp, 1'b0)
    wr(12'(osdsh_pkg::A_PAL_BASE + 28), 32'h9900_0000);
    wr(12'h008, 32'h3 << osdsh_pkg::BMP_BW_LSB);
    frame();
    px(1'b0, 16'h01B7);
    `CHK(pal_addr, 8'hB7)
    px(1'b1, 16'h0001);
    `CHK(pal_addr, 8'h99)
    wr(osdsh_pkg::A_IRQ_ST, 32'h1);
    wr(osdsh_pkg::A_IRQ_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK(frame_irq, 1'b0)
    frame();
    `CHK(frame_irq, 1'b1)
    wr(osdsh_pkg::A_IRQ_ST, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK(frame_irq, 1'b0)
    wr(osdsh_pkg::A_IRQ_MASK, 32'h0);
    frame();
    `CHK(frame_irq, 1'b0)
    rd(osdsh_pkg::A_IRQ_ST);
    `CHK(d[0], 1'b1)
    // Pixel reads hold off the lookup write so busy can be seen
    tab_en <= 1'b1;
    wr(osdsh_pkg::A_TYCB, 32'h5AC3);
    wr(osdsh_pkg::A_TCR, 32'h9607);
    rd(osdsh_pkg::A_CTRL);
    `CHK(d[8], 1'b1)
    tab_en <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(osdsh_pkg::A_CTRL);
    `CHK(d[8], 1'b0)
    tab_addr <= 8'h07;
    tab_en <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK(tab_data, 24'h5AC396)
    tab_en <= 1'b0;
    // Pending write must not survive a reset into the next frame
    wr(12'h054, 32'h1357_9BDF);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    frame();
    `CHK(act[32*21 +: 32], 32'h0)
    rd(12'h054);
    `CHK(d, 32'h0)
    tab_en <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(tab_data, 24'h5AC396)
    tab_en <= 1'b0;
    close_out();
  end
endmodule
